// ==== src/ievr_defs.svh ====
/*
  Register offsets, field positions and reset values of the interrupt event router.
  Assumes an 8-bit register port with one register per address.
*/
`ifndef IEVR_DEFS_SVH
`define IEVR_DEFS_SVH

`define IEVR_ADDR_W          8
`define IEVR_DATA_W          8
`define IEVR_OFS_STATUS_LINK 8'h24
`define IEVR_OFS_STATUS_CV0  8'h25
`define IEVR_OFS_STATUS_CV1  8'h26
`define IEVR_OFS_STATUS_CLK  8'h27
`define IEVR_OFS_SEL_LINK    8'h28
`define IEVR_OFS_SEL_CV0     8'h29
`define IEVR_OFS_SEL_CV1     8'h2a
`define IEVR_OFS_SEL_CLK     8'h2b
`define IEVR_OFS_STATUS_ALL  8'h2c
`define IEVR_OFS_EN_LINK     8'h30
`define IEVR_OFS_EN_CV0      8'h31
`define IEVR_OFS_EN_CV1      8'h32
`define IEVR_OFS_EN_CLK      8'h33
`define IEVR_OFS_PIN_STATE   8'h34
`define IEVR_OFS_SUM_STATUS  8'h35
`define IEVR_OFS_SUM_MASK    8'h36
`define IEVR_MASK_LINK       8'h1f
`define IEVR_MASK_CV         8'h09
`define IEVR_MASK_CLK        8'h33
`define IEVR_SEL_RESET       8'h00
`define IEVR_EN_RESET        8'h00
`define IEVR_BIT_STATUS_ALL  0

`endif

// ==== src/ievr_pkg.sv ====
/*
  Types shared by the interrupt event router files.
  Assumes the constants header is included where offsets are needed.
*/
package ievr_pkg;
  typedef enum logic [1:0] {
    IEVR_GRP_LINK = 2'h0,
    IEVR_GRP_CV0  = 2'h1,
    IEVR_GRP_CV1  = 2'h2,
    IEVR_GRP_CLK  = 2'h3
  } ievr_group_t;
  typedef logic [7:0] ievr_byte_t;
endpackage

// ==== src/ievr_grp_if.sv ====
/*
  Interface joining the router top to one event group slice.
  Assumes one clock domain.
*/
`timescale 1ns/10ps
interface ievr_grp_if;
  ievr_pkg::ievr_byte_t live;
  ievr_pkg::ievr_byte_t enable;
  ievr_pkg::ievr_byte_t select;
  ievr_pkg::ievr_byte_t clr_bits;
  ievr_pkg::ievr_byte_t status;
  logic                 pin_first;
  logic                 pin_second;
  modport top   (output live, output enable, output select, output clr_bits,
                 input status, input pin_first, input pin_second);
  modport slice (input live, input enable, input select, input clr_bits,
                 output status, output pin_first, output pin_second);
endinterface

// ==== src/ievr_group.sv ====
/*
  One group of up to eight interrupt events: latches, live view and pin routing.
  Assumes event inputs are synchronous to core_clk.
*/
`timescale 1ns/10ps
module ievr_group #(
  parameter logic [7:0] VALID = 8'hff
) (
  input  wire logic  core_clk,   // Register clock.
  input  wire logic  srst,       // Synchronous reset, active high.
  ievr_grp_if.slice  g           // Group signals.
);
  logic [7:0] latch_r;
  logic [7:0] to_first;
  logic [7:0] to_second;

  // Latch while enabled; a new event beats a write-one clear in the same cycle.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      latch_r <= 8'h00;
    end else begin
      latch_r <= ((latch_r & ~g.clr_bits) | g.live) & g.enable & VALID; // see (RL2) (RL3)
    end
  end

  genvar i;
  for (i = 0; i < 8; i++) begin : g_bit
    assign g.status[i]  = g.enable[i] ? latch_r[i] : (g.live[i] & VALID[i]); // see (RL1)
    assign to_first[i]  = latch_r[i] & g.enable[i] & ~g.select[i];  // see (RL4) (RL5)
    assign to_second[i] = latch_r[i] & g.enable[i] & g.select[i];   // see (RL4) (RL5)
  end

  assign g.pin_first  = |to_first;  // see (RL7)
  assign g.pin_second = |to_second; // see (RL7)
endmodule

// ==== src/ievr_router.sv ====
/*
  Interrupt event router: event status, enables, pin selectors, two active-low pins.
  Assumes a one-cycle register port with read data one cycle after the read strobe.
*/
// Implementation choice: the plain strobed port.
// Summary of operation
// (RL1) With an event's enable clear, its status flag shows the live condition and no pin moves.
// (RL2) With the enable set, the flag latches on the event and pulls the selected pin low.
// (RL3) Writing one to a latched flag clears it and releases the pin for that event.
// (RL4) A selector bit of 0 routes to the first pin and 1 to the second; selectors reset to 0.
// (RL5) A selector only acts while its event's enable is set.
// (RL6) A summary flag ORs all flags; writing one to it clears every latched flag.
// (RL7) A pin stays low while any latched, enabled event routed to it remains uncleared.
`timescale 1ns/10ps
`include "ievr_defs.svh"
module ievr_router (
  input  wire logic       core_clk,         // 40 MHz register clock.
  input  wire logic       srst,             // Synchronous reset, active high.
  input  wire logic [7:0] addr,             // Register address.
  input  wire logic [7:0] wdata,            // Write data.
  input  wire logic       wr_stb,           // Write strobe.
  input  wire logic       rd_stb,           // Read strobe.
  output logic      [7:0] rdata,            // Read data, one cycle after rd_stb.
  input  wire logic [4:0] ev_link,          // Jitter, ready, lane, pattern ch1, ch0.
  input  wire logic [1:0] ev_conv0,         // Calibrated, amp protect error.
  input  wire logic [1:0] ev_conv1,         // Calibrated, amp protect error.
  input  wire logic [3:0] ev_clock,         // Delay lost, delay locked, pll lost, pll locked.
  output logic            interrupt_pin_first_n,  // First pin, low when asserted.
  output logic            interrupt_pin_second_n, // Second pin, low when asserted.
  output logic            summary_irq       // Level interrupt from masked summary status.
);
  ievr_grp_if gi[4] ();
  logic [7:0] live    [4];
  logic [7:0] en_r    [4];
  logic [7:0] sel_r   [4];
  logic [7:0] clr     [4];
  logic [7:0] vmask   [4];
  logic [7:0] ofs_st  [4];
  logic [7:0] ofs_sel [4];
  logic [7:0] ofs_en  [4];
  logic [7:0] rdata_nxt;
  logic [3:0] pf;
  logic [3:0] ps;
  logic       any_status;
  logic       clear_all;
  logic [1:0] sum_stat_r;
  logic [1:0] sum_mask_r;
  logic [1:0] sum_ev;
  logic       pin_first_r;
  logic       pin_second_r;

  assign live[0] = {3'h0, ev_link};
  assign live[1] = {4'h0, ev_conv0[1], 2'h0, ev_conv0[0]};
  assign live[2] = {4'h0, ev_conv1[1], 2'h0, ev_conv1[0]};
  assign live[3] = {2'h0, ev_clock[3:2], 2'h0, ev_clock[1:0]};
  assign vmask[0] = `IEVR_MASK_LINK;
  assign vmask[1] = `IEVR_MASK_CV;
  assign vmask[2] = `IEVR_MASK_CV;
  assign vmask[3] = `IEVR_MASK_CLK;
  assign ofs_st[0] = `IEVR_OFS_STATUS_LINK;
  assign ofs_st[1] = `IEVR_OFS_STATUS_CV0;
  assign ofs_st[2] = `IEVR_OFS_STATUS_CV1;
  assign ofs_st[3] = `IEVR_OFS_STATUS_CLK;
  assign ofs_sel[0] = `IEVR_OFS_SEL_LINK;
  assign ofs_sel[1] = `IEVR_OFS_SEL_CV0;
  assign ofs_sel[2] = `IEVR_OFS_SEL_CV1;
  assign ofs_sel[3] = `IEVR_OFS_SEL_CLK;
  assign ofs_en[0] = `IEVR_OFS_EN_LINK;
  assign ofs_en[1] = `IEVR_OFS_EN_CV0;
  assign ofs_en[2] = `IEVR_OFS_EN_CV1;
  assign ofs_en[3] = `IEVR_OFS_EN_CLK;

  assign clear_all = wr_stb && (addr == `IEVR_OFS_STATUS_ALL) &&
                     wdata[`IEVR_BIT_STATUS_ALL];

  ////////////////////////////////////////////////////////////////////////////////
  genvar k;
  for (k = 0; k < 4; k++) begin : g_grp
    // Reserved enable and selector bits are dropped on write and read back as zero.
    always_ff @(posedge core_clk) begin
      if (srst) begin
        en_r[k] <= `IEVR_EN_RESET;
      end else if (wr_stb && addr == ofs_en[k]) begin
        en_r[k] <= wdata & vmask[k]; // see (RL5)
      end
    end

    always_ff @(posedge core_clk) begin
      if (srst) begin
        sel_r[k] <= `IEVR_SEL_RESET; // see (RL4)
      end else if (wr_stb && addr == ofs_sel[k]) begin
        sel_r[k] <= wdata & vmask[k]; // see (RL4)
      end
    end

    // Write-one clears of single flags, or all at once from the summary bit.
    assign clr[k] = clear_all ? 8'hff :
                    ((wr_stb && addr == ofs_st[k]) ? wdata : 8'h00); // see (RL3) (RL6)

    assign gi[k].live     = live[k];
    assign gi[k].enable   = en_r[k];
    assign gi[k].select   = sel_r[k];
    assign gi[k].clr_bits = clr[k];
    assign pf[k] = gi[k].pin_first;
    assign ps[k] = gi[k].pin_second;

    ievr_group #(.VALID(k == 0 ? `IEVR_MASK_LINK :
                        k == 3 ? `IEVR_MASK_CLK : `IEVR_MASK_CV)) u_grp (
      .core_clk (core_clk),
      .srst     (srst),
      .g        (gi[k])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign any_status = |{gi[0].status, gi[1].status, gi[2].status, gi[3].status}; // see (RL6)

  // Pins come from flops so they are glitch free at the package ball.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_first_r  <= 1'b0;
      pin_second_r <= 1'b0;
    end else begin
      pin_first_r  <= |pf; // see (RL7)
      pin_second_r <= |ps; // see (RL7)
    end
  end

  assign interrupt_pin_first_n  = ~pin_first_r;
  assign interrupt_pin_second_n = ~pin_second_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky summary: bit0 first pin asserted, bit1 second pin asserted.
  assign sum_ev = {pin_second_r, pin_first_r};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sum_stat_r <= 2'h0;
    end else if (rd_stb && addr == `IEVR_OFS_SUM_STATUS) begin
      sum_stat_r <= sum_ev;
    end else begin
      sum_stat_r <= sum_stat_r | sum_ev;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sum_mask_r <= 2'h0;
    end else if (wr_stb && addr == `IEVR_OFS_SUM_MASK) begin
      sum_mask_r <= wdata[1:0];
    end
  end

  assign summary_irq = |(sum_stat_r & sum_mask_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Unmapped addresses read as zero; the read register applies the strobe.
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (addr)
      `IEVR_OFS_STATUS_LINK: begin
        rdata_nxt = gi[0].status; // see (RL1)
      end
      `IEVR_OFS_STATUS_CV0: begin
        rdata_nxt = gi[1].status; // see (RL1)
      end
      `IEVR_OFS_STATUS_CV1: begin
        rdata_nxt = gi[2].status; // see (RL1)
      end
      `IEVR_OFS_STATUS_CLK: begin
        rdata_nxt = gi[3].status; // see (RL1)
      end
      `IEVR_OFS_SEL_LINK: begin
        rdata_nxt = sel_r[0];
      end
      `IEVR_OFS_SEL_CV0: begin
        rdata_nxt = sel_r[1];
      end
      `IEVR_OFS_SEL_CV1: begin
        rdata_nxt = sel_r[2];
      end
      `IEVR_OFS_SEL_CLK: begin
        rdata_nxt = sel_r[3];
      end
      `IEVR_OFS_STATUS_ALL: begin
        rdata_nxt = {7'h00, any_status}; // see (RL6)
      end
      `IEVR_OFS_EN_LINK: begin
        rdata_nxt = en_r[0];
      end
      `IEVR_OFS_EN_CV0: begin
        rdata_nxt = en_r[1];
      end
      `IEVR_OFS_EN_CV1: begin
        rdata_nxt = en_r[2];
      end
      `IEVR_OFS_EN_CLK: begin
        rdata_nxt = en_r[3];
      end
      `IEVR_OFS_PIN_STATE: begin
        rdata_nxt = {6'h00, pin_second_r, pin_first_r};
      end
      `IEVR_OFS_SUM_STATUS: begin
        rdata_nxt = {6'h00, sum_stat_r};
      end
      `IEVR_OFS_SUM_MASK: begin
        rdata_nxt = {6'h00, sum_mask_r};
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

// ==== verification/ievr_router_assertions.sv ====
/* Port checker for the interrupt event router.
   Assumes it is bound to every ievr_router instance. */
`timescale 1ns/10ps
module ievr_router_assertions (
  input wire logic [7:0] addr,                   // Address.
  input wire logic [7:0] wdata,                  // Write data.
  input wire logic [7:0] rdata,                  // Read data.
  input wire logic [4:0] ev_link,                // Link events.
  input wire logic [1:0] ev_conv0,               // Converter 0 events.
  input wire logic [1:0] ev_conv1,               // Converter 1 events.
  input wire logic [3:0] ev_clock,               // Clock events.
  input wire logic       core_clk,               // Clock.
  input wire logic       srst,                   // Reset.
  input wire logic       wr_stb,                 // Write strobe.
  input wire logic       rd_stb,                 // Read strobe.
  input wire logic       interrupt_pin_first_n,  // First pin.
  input wire logic       interrupt_pin_second_n  // Second pin.
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic       ev_idle;
  logic       quiet;
  logic       wrote_r;
  logic [1:0] pin;
  assign ev_idle = !(|{ev_link, ev_conv0, ev_conv1, ev_clock});
  assign quiet = !wr_stb && ev_idle;
  assign pin = {interrupt_pin_second_n, interrupt_pin_first_n};
  // Remembers whether software has written anything since reset.
  always_ff @(posedge core_clk) begin
    wrote_r <= srst ? 1'b0 : (wrote_r | wr_stb);
  end
  ////////////////////////////////////////////////////////////////
  a_no_enable_quiet: assert property (!wrote_r |-> pin == 2'b11)
    else $error("pin moved with all enables clear");
  a_sel_reserved: assert property (
    $past(rd_stb) && $past(addr) == 8'h28 |-> rdata[7:5] == 3'h0)
    else $error("selector reserved bits not zero");
  a_sum_reserved: assert property (
    $past(rd_stb) && $past(addr) == 8'h2c |-> rdata[7:1] == 7'h00)
    else $error("summary reserved bits not zero");
  a_clear_all_release: assert property (
    wr_stb && addr == 8'h2c && wdata[0] && ev_idle |-> ##2 pin == 2'b11)
    else $error("pins held after clear all");
  a_pins_hold_quiet: assert property (quiet [*3] |=> $stable(pin))
    else $error("pin changed without a cause");
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (
    $past(rd_stb) && $past(addr) == 8'h40 |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_reserved: assert property (
    $past(rd_stb) && $past(addr) == 8'h27 |-> rdata[7:6] == 2'h0)
    else $error("status reserved bits not zero");
endmodule
bind ievr_router ievr_router_assertions i_ievr_router_assertions (.addr, .wdata, .rdata,
  .ev_link, .ev_conv0, .ev_conv1, .ev_clock, .core_clk, .srst, .wr_stb, .rd_stb,
  .interrupt_pin_first_n, .interrupt_pin_second_n);

// ==== verification/ievr_host_model.sv ====
/* Host model: samples the two active-low pins once a clock.
   Assumes the pins are levels in the core_clk domain. */
`timescale 1ns/10ps
module ievr_host_model (
  input  wire logic       core_clk,     // Clock.
  input  wire logic       srst,         // Reset.
  input  wire logic       pin_first_n,  // First pin.
  input  wire logic       pin_second_n, // Second pin.
  output logic      [1:0] seen          // Asserted pins, second and first.
);
  always_ff @(posedge core_clk) begin
    seen <= srst ? 2'b00 : {~pin_second_n, ~pin_first_n};
  end
endmodule

// ==== verification/ievr_router_tb.sv ====
/* Bench for the interrupt event router: register tasks, event pulses, pin checks.
   Assumes the host model reports the pins one clock late. */
`timescale 1ns/10ps
module ievr_router_tb;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic  [7:0] addr = 8'h00;
  logic  [7:0] wdata = 8'h00;
  logic  [7:0] rdata;
  logic [12:0] ev = 13'h0000;
  logic        pf_n;
  logic        ps_n;
  logic        irq;
  logic  [1:0] hv;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic  [7:0] msk [4] = '{8'h1f, 8'h09, 8'h09, 8'h33};
  logic [12:0] evv [4] = '{13'h1f00, 13'h00c0, 13'h0030, 13'h000f};
  always #12.5 core_clk = ~core_clk;
  ievr_router i_ievr_router (.core_clk, .srst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .ev_link(ev[12:8]), .ev_conv0(ev[7:6]), .ev_conv1(ev[5:4]), .ev_clock(ev[3:0]),
    .interrupt_pin_first_n(pf_n), .interrupt_pin_second_n(ps_n), .summary_irq(irq));
  ievr_host_model i_ievr_host_model (.core_clk, .srst, .pin_first_n(pf_n),
    .pin_second_n(ps_n), .seen(hv));
  ////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pins(input logic [1:0] exp);
    repeat (3) @(posedge core_clk);
    #1 cmp({6'h00, hv}, {6'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 cmp(rdata, e);
  endtask
  task automatic pulse(input logic [12:0] v);
    @(posedge core_clk);
    ev <= v;
    @(posedge core_clk);
    ev <= 13'h0000;
  endtask
  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    for (int g = 0; g < 4; g++) rd(8'h28 + 8'(g), 8'h00);
    @(posedge core_clk);
    ev <= 13'h0001;
    rd(8'h27, 8'h01);
    ev <= 13'h0000;
    pins(2'b00);
    rd(8'h27, 8'h00);
    $display("test live view done");
    wr(8'h2b, 8'h01);
    pulse(13'h0001);
    pins(2'b00);
    wr(8'h2b, 8'h00);
    wr(8'h33, 8'h01);
    pulse(13'h0001);
    pins(2'b01);
    rd(8'h27, 8'h01);
    wr(8'h27, 8'h01);
    pins(2'b00);
    rd(8'h27, 8'h00);
    // An event in the very cycle of a clear keeps the flag set.
    fork
      wr(8'h27, 8'h01);
      pulse(13'h0001);
    join
    rd(8'h27, 8'h01);
    wr(8'h2c, 8'h01);
    $display("test latch and clear done");
    for (int g = 0; g < 4; g++) begin
      wr(8'h28 + 8'(g), 8'hff);
      wr(8'h30 + 8'(g), 8'hff);
      rd(8'h28 + 8'(g), msk[g]);
      rd(8'h30 + 8'(g), msk[g]);
      pulse(evv[g]);
      pins(2'b10);
      rd(8'h24 + 8'(g), msk[g]);
      rd(8'h2c, 8'h01);
      wr(8'h2c, 8'h01);
      pins(2'b00);
      rd(8'h24 + 8'(g), 8'h00);
      wr(8'h30 + 8'(g), 8'h00);
      wr(8'h28 + 8'(g), 8'h00);
    end
    $display("test routing done");
    wr(8'h36, 8'hff);
    rd(8'h36, 8'h03);
    wr(8'h33, 8'h03);
    pulse(13'h0003);
    pins(2'b01);
    rd(8'h34, 8'h01);
    cmp({7'h00, irq}, 8'h01);
    wr(8'h27, 8'h01);
    pins(2'b01);
    wr(8'h27, 8'h02);
    pins(2'b00);
    // Both pins were asserted by the earlier tests and the summary is sticky.
    rd(8'h35, 8'h03);
    cmp({7'h00, irq}, 8'h00);
    wr(8'h36, 8'h00);
    pulse(13'h0001);
    pins(2'b01);
    cmp({7'h00, irq}, 8'h00);
    wr(8'h2c, 8'h01);
    pins(2'b00);
    rd(8'h35, 8'h01);
    wr(8'h33, 8'h00);
    $display("test interrupt done");
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
    $display("test unmapped done");
    print_verdict;
  end
endmodule
